/* File: rocof_pkg.sv */
// Constants and types for the rate-of-change-of-frequency stage
`default_nettype none
package rocof_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ    = 10_000_000;
  localparam int TICK_MS   = 5;
  localparam int TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
  localparam int DFDT_GAIN = 1000 / TICK_MS;
  localparam int PRE_MS    = 20;
  localparam int PRE_TICKS = PRE_MS / TICK_MS;
  localparam logic [31:0] HYST_MHZS = 32'h0000_0064;
  // ==========================================================
  // Widths and depths
  localparam int ADDR_W    = 8;
  localparam int FREQ_W    = 24;
  localparam int TM_W      = 19;
  localparam int CNT_W     = 16;
  localparam int REC_DEPTH = 12;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_PICKUP  = 8'h04;
  localparam logic [7:0] A_OPDLY   = 8'h08;
  localparam logic [7:0] A_RSTDLY  = 8'h0C;
  localparam logic [7:0] A_EVSEL   = 8'h10;
  localparam logic [7:0] A_CNTCLR  = 8'h14;
  localparam logic [7:0] A_TIME    = 8'h18;
  localparam logic [7:0] A_STATUS  = 8'h1C;
  localparam logic [7:0] A_DFDT    = 8'h20;
  localparam logic [7:0] A_RATIO   = 8'h24;
  localparam logic [7:0] A_EXPT    = 8'h28;
  localparam logic [7:0] A_REMAIN  = 8'h2C;
  localparam logic [7:0] A_CNT0    = 8'h30;
  localparam logic [7:0] A_CNT1    = 8'h34;
  localparam logic [7:0] A_CNT2    = 8'h38;
  localparam logic [7:0] A_RECSEL  = 8'h3C;
  localparam logic [7:0] A_RSTAMP  = 8'h40;
  localparam logic [7:0] A_RINFO   = 8'h44;
  localparam logic [7:0] A_RPRED   = 8'h48;
  localparam logic [7:0] A_RPREF   = 8'h4C;
  localparam logic [7:0] A_RFLTD   = 8'h50;
  localparam logic [7:0] A_RFLTF   = 8'h54;
  // ==========================================================
  // Fields and reset values
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int INFO_GRP_LSB  = 8;
  localparam int RSEL_CNT_LSB  = 8;
  localparam logic [15:0]     PICKUP_RST = 16'h00C8;
  localparam logic [TM_W-1:0] OPDLY_RST  = 19'h0_0014;
  localparam logic [TM_W-1:0] RSTDLY_RST = 19'h0_0004;
  localparam logic [5:0]      EVSEL_RST  = 6'h3F;
  localparam logic [1:0]      RESP_OK    = 2'h0;
  localparam logic [1:0]      RESP_ERR   = 2'h2;
  // ==========================================================
  // Record layout
  localparam int REC_FLTF = 0;
  localparam int REC_FLTD = 24;
  localparam int REC_PREF = 56;
  localparam int REC_PRED = 80;
  localparam int REC_CODE = 112;
  localparam int REC_GRP  = 115;
  localparam int REC_STMP = 118;
  localparam int REC_W    = 150;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    COND_NORMAL  = 2'b00,
    COND_START   = 2'b01,
    COND_TRIP    = 2'b10,
    COND_BLOCKED = 2'b11
  } rocof_cond_t;
  typedef enum logic [1:0] {
    MODE_RISE = 2'b00,
    MODE_FALL = 2'b01,
    MODE_BOTH = 2'b10
  } rocof_mode_t;
endpackage : rocof_pkg
`default_nettype wire

/* File: rocof_tick.sv */
// Processing-cycle tick divider
`timescale 1ns/1ps
`default_nettype none
module rocof_tick #(
  parameter int unsigned CYCLES = 1
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Tick
  output logic      tick
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_cnt  = cnt + 32'h0000_0001;
    if (cnt >= 32'(CYCLES - 1)) begin
      next_cnt  = 32'h0000_0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt  <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : rocof_tick
`default_nettype wire

/* File: rocof_rec_store.sv */
// Ring store of the newest operation records
`timescale 1ns/1ps
`default_nettype none
module rocof_rec_store
  import rocof_pkg::*;
(
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [REC_W-1:0] wr_data,
  // Read side, index 0 is newest
  input  wire logic [3:0]       rd_idx,
  output logic      [REC_W-1:0] rd_data,
  output logic      [3:0]       count
);
  logic [REC_W-1:0] mem [REC_DEPTH];
  logic [3:0]       ptr;
  logic [3:0]       next_ptr;
  logic [3:0]       next_count;
  logic [4:0]       pos;

  always_comb begin
    next_ptr   = ptr;
    next_count = count;
    if (wr_en) begin
      next_ptr = (ptr == 4'(REC_DEPTH - 1)) ? 4'h0 : ptr + 4'h1;
      if (count != 4'(REC_DEPTH))
        next_count = count + 4'h1;
    end
    pos = 5'(ptr) + 5'(REC_DEPTH - 1) - 5'(rd_idx);
    if (pos >= 5'(REC_DEPTH))
      pos = pos - 5'(REC_DEPTH);
    rd_data = (rd_idx < count) ? mem[pos[3:0]] : '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr   <= 4'h0;
      count <= 4'h0;
    end else begin
      ptr   <= next_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_en)
      mem[ptr] <= wr_data;
  end
endmodule : rocof_rec_store
`default_nettype wire

/* File: rocof_stage.sv */
// Rate-of-change-of-frequency stage with blocking, events and records
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rocof_stage
  import rocof_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Relay side inputs
  input  wire logic              block_in,
  input  wire logic [FREQ_W-1:0] freq_in,
  input  wire logic [2:0]        group_in,
  // Stage outputs
  output logic                   start_o,
  output logic                   trip_o,
  output logic                   blocked_o,
  output rocof_cond_t            condition,
  // Event port
  output logic                   evt_valid,
  output logic [5:0]             evt_mask,
  output logic [31:0]            evt_stamp
);
  // ==========================================================
  // State
  logic                     tick;
  logic                     eval;
  logic                     have_prev;
  logic                     blk_s;
  logic [FREQ_W-1:0]        freq_s;
  logic signed [31:0]       dfdt;
  logic signed [31:0]       hist_d [PRE_TICKS];
  logic [FREQ_W-1:0]        hist_f [PRE_TICKS];
  logic                     pick;
  rocof_cond_t              st;
  logic [TM_W-1:0]          op_cnt;
  logic [TM_W-1:0]          rel_cnt;
  logic [15:0]              ratio;
  logic [31:0]              time_ms;
  logic [CNT_W-1:0]         cnt [3];
  logic                     en;
  rocof_mode_t              mode;
  logic [15:0]              pickup;
  logic [TM_W-1:0]          op_dly;
  logic [TM_W-1:0]          rst_dly;
  logic [5:0]               ev_sel;
  logic [3:0]               rec_sel;
  logic                     aw_hold;
  logic                     w_hold;
  logic [ADDR_W-1:0]        awa;
  logic [31:0]              wda;
  logic [3:0]               wsa;
  // ==========================================================
  // Next values
  logic                     next_eval;
  logic                     next_have_prev;
  logic                     next_blk_s;
  logic [FREQ_W-1:0]        next_freq_s;
  logic signed [31:0]       next_dfdt;
  logic signed [31:0]       next_hist_d [PRE_TICKS];
  logic [FREQ_W-1:0]        next_hist_f [PRE_TICKS];
  logic                     next_pick;
  rocof_cond_t              next_st;
  logic [TM_W-1:0]          next_op_cnt;
  logic [TM_W-1:0]          next_rel_cnt;
  logic [15:0]              next_ratio;
  logic [31:0]              next_time_ms;
  logic [CNT_W-1:0]         next_cnt [3];
  logic                     next_en;
  rocof_mode_t              next_mode;
  logic [15:0]              next_pickup;
  logic [TM_W-1:0]          next_op_dly;
  logic [TM_W-1:0]          next_rst_dly;
  logic [5:0]               next_ev_sel;
  logic [3:0]               next_rec_sel;
  logic                     next_aw_hold;
  logic                     next_w_hold;
  logic [ADDR_W-1:0]        next_awa;
  logic [31:0]              next_wda;
  logic [3:0]               next_wsa;
  logic                     next_awready;
  logic                     next_wready;
  logic                     next_arready;
  logic                     next_bvalid;
  logic [1:0]               next_bresp;
  logic                     next_rvalid;
  logic [1:0]               next_rresp;
  logic [31:0]              next_rdata;
  logic [2:0]               next_outs;
  logic                     next_evt_valid;
  logic [5:0]               next_evt_mask;
  logic [31:0]              next_evt_stamp;
  // ==========================================================
  // Helpers
  logic [31:0]              mag;
  logic                     dir_ok;
  logic [2:0]               on_ev;
  logic [2:0]               off_ev;
  logic [2:0]               clr;
  logic                     wr_go;
  logic                     wr_ok;
  logic [REC_W-1:0]         rec_wdata;
  logic [REC_W-1:0]         rec_rdata;
  logic [3:0]               rec_count;
  logic [2:0]               rec_code;
  logic [39:0]              prod;
  logic signed [FREQ_W:0]   fdiff;
  logic signed [TM_W:0]     remain;

  rocof_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  rocof_rec_store u_rec (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (eval && (|on_ev)),
    .wr_data (rec_wdata),
    .rd_idx  (rec_sel),
    .rd_data (rec_rdata),
    .count   (rec_count)
  );

  // ==========================================================
  // Combinational next state
  always_comb begin
    // Sampling on the 5 ms tick
    next_eval      = tick;
    next_have_prev = have_prev;
    next_blk_s     = blk_s;
    next_freq_s    = freq_s;
    next_dfdt      = dfdt;
    next_hist_d    = hist_d;
    next_hist_f    = hist_f;
    next_time_ms   = time_ms;
    fdiff          = $signed({1'b0, freq_in}) - $signed({1'b0, freq_s});
    if (tick) begin
      next_blk_s     = block_in;
      next_freq_s    = freq_in;
      next_have_prev = 1'b1;
      next_dfdt      = have_prev ? 32'(fdiff * DFDT_GAIN) : '0;
      next_hist_d[0] = dfdt;
      next_hist_f[0] = freq_s;
      for (int i = 1; i < PRE_TICKS; i++) begin
        next_hist_d[i] = hist_d[i-1];
        next_hist_f[i] = hist_f[i-1];
      end
      next_time_ms   = time_ms + 32'(TICK_MS);
    end
    // Pick-up with direction and drop-out hysteresis
    mag = dfdt[31] ? 32'(-dfdt) : 32'(dfdt);
    case (mode)
      MODE_RISE: dir_ok = !dfdt[31] && (dfdt != 0);
      MODE_FALL: dir_ok = dfdt[31];
      MODE_BOTH: dir_ok = 1'b1;
      default:   dir_ok = 1'b0;
    endcase
    prod       = 40'(mag) * 40'(DFDT_GAIN);
    next_ratio = (pickup == 16'h0000) ? 16'h0000 : 16'(prod / 40'(pickup));
    next_pick  = pick;
    next_st    = st;
    next_op_cnt  = op_cnt;
    next_rel_cnt = rel_cnt;
    if (eval) begin
      if (pick)
        next_pick = en && dir_ok && (mag + HYST_MHZS >= 32'(pickup));
      else
        next_pick = en && dir_ok && (mag >= 32'(pickup));
      case (st)
        COND_NORMAL: begin
          if (next_pick)
            next_st = blk_s ? COND_BLOCKED : COND_START;
        end
        COND_START: begin
          if (!next_pick)
            next_st = COND_NORMAL;
          else if (blk_s)
            next_st = COND_BLOCKED;
        end
        COND_TRIP: begin
          if (!next_pick)
            next_st = COND_NORMAL;
          else if (blk_s)
            next_st = COND_BLOCKED;
        end
        COND_BLOCKED: begin
          if (!next_pick)
            next_st = COND_NORMAL;
          else if (!blk_s)
            next_st = COND_START;
        end
        default: next_st = COND_NORMAL;
      endcase
      if (next_st == COND_START) begin
        next_rel_cnt = '0;
        if (op_cnt + 19'h0_0001 >= op_dly)
          next_st = COND_TRIP;
        else
          next_op_cnt = op_cnt + 19'h0_0001;
      end else if (next_st != COND_TRIP && op_cnt != '0) begin
        if (rel_cnt + 19'h0_0001 >= rst_dly) begin
          next_op_cnt  = '0;
          next_rel_cnt = '0;
        end else begin
          next_rel_cnt = rel_cnt + 19'h0_0001;
        end
      end
    end
    // Output edges and events
    next_outs = {next_st == COND_BLOCKED, next_st == COND_TRIP, next_st == COND_START};
    on_ev     = eval ? (next_outs & ~{blocked_o, trip_o, start_o}) : 3'h0;
    off_ev    = eval ? (~next_outs & {blocked_o, trip_o, start_o}) : 3'h0;
    next_evt_mask = 6'h00;
    rec_code  = 3'h0;
    for (int i = 0; i < 3; i++) begin
      next_evt_mask[2*i]   = on_ev[i] && ev_sel[2*i];
      next_evt_mask[2*i+1] = off_ev[i] && ev_sel[2*i+1];
      if (on_ev[i])
        rec_code = 3'(2 * i);
    end
    next_evt_valid = |next_evt_mask;
    next_evt_stamp = next_evt_valid ? time_ms : evt_stamp;
    rec_wdata = '0;
    rec_wdata[REC_FLTF +: FREQ_W] = freq_s;
    rec_wdata[REC_FLTD +: 32]     = dfdt;
    rec_wdata[REC_PREF +: FREQ_W] = hist_f[PRE_TICKS-1];
    rec_wdata[REC_PRED +: 32]     = hist_d[PRE_TICKS-1];
    rec_wdata[REC_CODE +: 3]      = rec_code;
    rec_wdata[REC_GRP +: 3]       = group_in;
    rec_wdata[REC_STMP +: 32]     = time_ms;
    remain = (st == COND_START) ? $signed({1'b0, op_dly}) - $signed({1'b0, op_cnt}) : '0;
    // AXI write channel
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_awa     = awa;
    next_wda     = wda;
    next_wsa     = wsa;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_awa     = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_wda    = s_axi_wdata;
      next_wsa    = s_axi_wstrb;
    end
    wr_go = aw_hold && w_hold && !s_axi_bvalid;
    case (awa)
      A_CTRL, A_PICKUP, A_OPDLY, A_RSTDLY, A_EVSEL,
      A_CNTCLR, A_TIME, A_RECSEL: wr_ok = 1'b1;
      default:                    wr_ok = 1'b0;
    endcase
    if (wr_go) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_ok ? RESP_OK : RESP_ERR;
    end
    next_awready = !next_aw_hold;
    next_wready  = !next_w_hold;
    // Register writes, full words only
    next_en      = en;
    next_mode    = mode;
    next_pickup  = pickup;
    next_op_dly  = op_dly;
    next_rst_dly = rst_dly;
    next_ev_sel  = ev_sel;
    next_rec_sel = rec_sel;
    clr          = 3'h0;
    if (wr_go && wsa == 4'hF) begin
      case (awa)
        A_CTRL: begin
          next_en   = wda[CTRL_EN_BIT];
          next_mode = rocof_mode_t'(wda[CTRL_MODE_LSB +: 2]);
        end
        A_PICKUP: next_pickup  = wda[15:0];
        A_OPDLY:  next_op_dly  = wda[TM_W-1:0];
        A_RSTDLY: next_rst_dly = wda[TM_W-1:0];
        A_EVSEL:  next_ev_sel  = wda[5:0];
        A_CNTCLR: clr          = wda[2:0];
        A_TIME:   next_time_ms = wda;
        A_RECSEL: next_rec_sel = wda[3:0];
        default:  clr          = 3'h0;
      endcase
    end
    // Counters: a new event wins over a clear
    for (int i = 0; i < 3; i++) begin
      next_cnt[i] = clr[i] ? '0 : cnt[i];
      if (on_ev[i])
        next_cnt[i] = next_cnt[i] + 16'h0001;
    end
    // AXI read channel
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rresp  = s_axi_rresp;
    next_rdata  = s_axi_rdata;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OK;
      next_rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        A_CTRL:   next_rdata = 32'({mode, en});
        A_PICKUP: next_rdata = 32'(pickup);
        A_OPDLY:  next_rdata = 32'(op_dly);
        A_RSTDLY: next_rdata = 32'(rst_dly);
        A_EVSEL:  next_rdata = 32'(ev_sel);
        A_CNTCLR: next_rdata = 32'h0000_0000;
        A_TIME:   next_rdata = time_ms;
        A_STATUS: next_rdata = 32'(st);
        A_DFDT:   next_rdata = dfdt;
        A_RATIO:  next_rdata = 32'(ratio);
        A_EXPT:   next_rdata = 32'(op_dly);
        A_REMAIN: next_rdata = 32'(remain);
        A_CNT0:   next_rdata = 32'(cnt[0]);
        A_CNT1:   next_rdata = 32'(cnt[1]);
        A_CNT2:   next_rdata = 32'(cnt[2]);
        A_RECSEL: next_rdata = 32'({rec_count, 4'h0, rec_sel});
        A_RSTAMP: next_rdata = rec_rdata[REC_STMP +: 32];
        A_RINFO:  next_rdata = 32'({rec_rdata[REC_GRP +: 3], 5'h00, rec_rdata[REC_CODE +: 3]});
        A_RPRED:  next_rdata = rec_rdata[REC_PRED +: 32];
        A_RPREF:  next_rdata = 32'(rec_rdata[REC_PREF +: FREQ_W]);
        A_RFLTD:  next_rdata = rec_rdata[REC_FLTD +: 32];
        A_RFLTF:  next_rdata = 32'(rec_rdata[REC_FLTF +: FREQ_W]);
        default:  next_rresp = RESP_ERR;
      endcase
    end
    next_arready = !next_rvalid;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eval <= 1'b0; have_prev <= 1'b0; blk_s <= 1'b0;
      freq_s <= '0; dfdt <= '0; pick <= 1'b0; st <= COND_NORMAL;
      hist_d <= '{default: '0}; hist_f <= '{default: '0};
      op_cnt <= '0; rel_cnt <= '0; ratio <= '0; time_ms <= '0;
      cnt <= '{default: '0};
      en <= 1'b0; mode <= MODE_RISE; pickup <= PICKUP_RST;
      op_dly <= OPDLY_RST; rst_dly <= RSTDLY_RST; ev_sel <= EVSEL_RST;
      rec_sel <= 4'h0; aw_hold <= 1'b0; w_hold <= 1'b0;
      awa <= '0; wda <= '0; wsa <= 4'h0;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0; s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= RESP_OK;
      s_axi_rvalid <= 1'b0; s_axi_rresp <= RESP_OK; s_axi_rdata <= '0;
      start_o <= 1'b0; trip_o <= 1'b0; blocked_o <= 1'b0;
      condition <= COND_NORMAL;
      evt_valid <= 1'b0; evt_mask <= 6'h00; evt_stamp <= '0;
    end else begin
      eval <= next_eval; have_prev <= next_have_prev; blk_s <= next_blk_s;
      freq_s <= next_freq_s; dfdt <= next_dfdt; pick <= next_pick; st <= next_st;
      hist_d <= next_hist_d; hist_f <= next_hist_f;
      op_cnt <= next_op_cnt; rel_cnt <= next_rel_cnt; ratio <= next_ratio;
      time_ms <= next_time_ms; cnt <= next_cnt;
      en <= next_en; mode <= next_mode; pickup <= next_pickup;
      op_dly <= next_op_dly; rst_dly <= next_rst_dly; ev_sel <= next_ev_sel;
      rec_sel <= next_rec_sel; aw_hold <= next_aw_hold; w_hold <= next_w_hold;
      awa <= next_awa; wda <= next_wda; wsa <= next_wsa;
      s_axi_awready <= next_awready; s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid <= next_bvalid; s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid; s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      start_o <= next_outs[0]; trip_o <= next_outs[1]; blocked_o <= next_outs[2];
      condition <= next_st;
      evt_valid <= next_evt_valid; evt_mask <= next_evt_mask;
      evt_stamp <= next_evt_stamp;
    end
  end
endmodule : rocof_stage
`default_nettype wire

/* File: rocof_stage_checker.sv */
// Port assertions for the rocof_stage stage
`timescale 1ns/1ps
`default_nettype none
module rocof_stage_checker
  import rocof_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Read handshake
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Stage
  input wire logic        block_in,
  input wire logic        start_o,
  input wire logic        trip_o,
  input wire logic        blocked_o,
  input wire rocof_cond_t condition,
  input wire logic        evt_valid,
  input wire logic [5:0]  evt_mask
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_one_hot: assert property ($onehot0({start_o, trip_o, blocked_o}))
    else $error("two stage outputs high");
  chk_cond_map: assert property (condition == (blocked_o ? COND_BLOCKED : trip_o ? COND_TRIP :
    start_o ? COND_START : COND_NORMAL)) else $error("condition disagrees with outputs");
  chk_evt_pulse: assert property (evt_valid |-> (evt_mask != 6'h00) ##1 !evt_valid)
    else $error("event pulse malformed");
  chk_start_on: assert property (evt_mask[0] |-> $rose(start_o))
    else $error("start on event without rise");
  chk_start_off: assert property (evt_mask[1] |-> $fell(start_o))
    else $error("start off event without fall");
  chk_trip_on: assert property (evt_mask[2] |-> $rose(trip_o))
    else $error("trip on event without rise");
  chk_trip_path: assert property ($rose(trip_o) |-> $past(start_o))
    else $error("trip without prior start");
  chk_start_free: assert property ($rose(start_o) |-> !$past(block_in, 2))
    else $error("start while blocked");
  chk_blk_wins: assert property ($rose(blocked_o) |-> $past(block_in, 2))
    else $error("blocked without block input");
  chk_ar_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read not answered");
endmodule : rocof_stage_checker
bind rocof_stage rocof_stage_checker u_chk (.*);
`default_nettype wire

/* File: rocof_relay_model.sv */
// Frequency source and blocking input model
`timescale 1ns/1ps
`default_nettype none
module rocof_relay_model
  import rocof_pkg::*;
(
  input wire logic              aclk,
  input wire logic              step_en,
  input wire logic [FREQ_W-1:0] base,
  input wire logic              blk_req,
  output logic                  block_in,
  output logic [FREQ_W-1:0]     freq_in
);
  // ==========================================================
  // Ramp one mHz a clock, else hold base
  always @(posedge aclk) begin
    freq_in <= step_en ? freq_in + 24'h00_0001 : base;
    block_in <= blk_req;
  end
endmodule : rocof_relay_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the rocof_stage stage
`timescale 1ns/1ps
`default_nettype none
module testbench import rocof_pkg::*;;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, step_en = 0, blk_req = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, evt_stamp;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic start_o, trip_o, blocked_o, evt_valid, block_in;
  logic [5:0] evt_mask;
  logic [FREQ_W-1:0] freq_in, base = 0;
  logic [2:0] group_in = 0;
  rocof_cond_t condition;
  logic [41:0] expq[$];
  logic [5:0] evq[$];
  int n_fail = 0, checked = 0, cyc = 0, seed = 56717;
  rocof_stage #(.TICK_CYCLES(20)) DUT (.*);
  rocof_relay_model u_far (.*);
  // ==========================================================
  // Tasks
  always #50 aclk = ~aclk;
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    expq.push_back({a, e});
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask : rd
  task automatic wait_cond(input rocof_cond_t c);
    repeat (2000) begin
      @(posedge aclk);
      if (condition === c) break;
    end
  endtask : wait_cond
  // ==========================================================
  // Monitor, timeout and main sequence
  logic [41:0] note;
  always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) begin
    note = expq.pop_front();
    check($sformatf("reg %h", note[41:34]), {s_axi_rresp, s_axi_rdata}, note[33:0]);
  end
  // Events: oldest noted mask, stamp is 5 ms per tick since release
  always @(posedge aclk) if (evt_valid) begin
    check("evt_mask", 34'(evt_mask), 34'(evq.pop_front()));
    check("evt_stamp", 34'(evt_stamp), 34'(TICK_MS * ((cyc - 13) / 20)));
  end
  always @(posedge aclk) if (++cyc == 20000) begin
    n_fail++;
    final_report();
  end
  initial begin
    base = 24'd50000 + 24'($random(seed) & 32'h0000_0FFF);
    group_in = 3'($random(seed));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(A_PICKUP, {RESP_OK, 32'h0000_00C8});
    rd(A_EXPT, {RESP_OK, 32'h0000_0014});
    rd(A_EVSEL, {RESP_OK, 32'h0000_003F});
    rd(A_STATUS, {RESP_OK, 32'h0000_0000});
    rd(8'h58, {RESP_ERR, 32'h0000_0000});
    wr(A_OPDLY, 32'h0000_0003);
    wr(A_CTRL, 32'h0000_0001);
    wr(A_EVSEL, 32'h0000_003D);
    evq = '{6'h01, 6'h04, 6'h18};
    step_en <= 1;
    wait_cond(COND_START);
    rd(A_STATUS, {RESP_OK, 32'h0000_0001});
    rd(A_REMAIN, {RESP_OK, 32'h0000_0002});
    wait_cond(COND_TRIP);
    rd(A_STATUS, {RESP_OK, 32'h0000_0002});
    rd(A_CNT0, {RESP_OK, 32'h0000_0001});
    rd(A_CNT1, {RESP_OK, 32'h0000_0001});
    rd(A_DFDT, {RESP_OK, 32'h0000_0FA0});
    rd(A_RATIO, {RESP_OK, 32'h0000_0FA0});
    blk_req <= 1;
    wait_cond(COND_BLOCKED);
    rd(A_STATUS, {RESP_OK, 32'h0000_0003});
    rd(A_CNT2, {RESP_OK, 32'h0000_0001});
    rd(A_RECSEL, {RESP_OK, 32'h0000_0300});
    rd(A_RINFO, {RESP_OK, 21'h0, group_in, 8'h04});
    wr(A_CNTCLR, 32'h0000_0007);
    rd(A_CNT0, {RESP_OK, 32'h0000_0000});
    check("evt_left", 34'(evq.size()), 34'h0);
    final_report();
  end
endmodule : testbench
`default_nettype wire
